// [core/tmr_pkg.sv]
package tmr_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_CONTROL = 8'hc8;
	localparam logic [7:0] ADDR_AUX = 8'hc9;
	localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'hce;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hcf;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_OVF_FLAG = 7;
	localparam int BIT_EXT_FLAG = 6;
	localparam int BIT_RX_BAUD = 5;
	localparam int BIT_TX_BAUD = 4;
	localparam int BIT_TRIG_EN = 3;
	localparam int BIT_RUN = 2;
	localparam int BIT_CT_SEL = 1;
	localparam int BIT_CAP_SEL = 0;
	localparam int BIT_AUX_SLOW_SEL = 0;
	localparam int BIT_AUX_WAVE_EN = 1;
	localparam int BIT_IRQ_OVF = 0;
	localparam int BIT_IRQ_EXT = 1;
	localparam int IRQ_BITS = 2;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_AUX = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] RST_RELOAD = 16'h0000;
	localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
	localparam int TIMER_DIV = 2;
	localparam int SLOW_DIV = 16;
	localparam int SYNC_PINS = 3;
	localparam int PIN_COUNT = 0;
	localparam int PIN_TRIGGER = 1;
	localparam int PIN_SLOW = 2;
	localparam logic [1:0] SERIAL_MODE_1 = 2'h1;
	localparam logic [1:0] SERIAL_MODE_3 = 2'h3;

	// ****************************************
	// Block state
	// ****************************************
	typedef struct packed {
		logic [7:0] control;
		logic [7:0] aux;
		logic [15:0] count;
		logic [15:0] reload;
		logic [IRQ_BITS-1:0] irq_status;
		logic [IRQ_BITS-1:0] irq_mask;
		logic [7:0] rd_data;
		logic irq;
		logic rx_tick;
		logic tx_tick;
		logic wave;
		logic wave_oe;
	} tmr_state_type;

endpackage

// [core/tmr_edge_sync.sv]
`timescale 1ns/10ps
module tmr_edge_sync
	import tmr_pkg::*;
#(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] fall_pulse
);

	// ****************************************
	// Two-stage synchroniser plus edge history
	// ****************************************
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] prev;
	} tmr_sync_type;

	tmr_sync_type sync_q;
	tmr_sync_type sync_d;

	always_comb begin
		sync_d = sync_q;
		sync_d.meta = pin_in;
		sync_d.sync = sync_q.meta;
		sync_d.prev = sync_q.sync;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_q <= '0;
		end else begin
			sync_q <= sync_d;
		end
	end

	// Falling edges seen only after the second stage
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_fall
			assign fall_pulse[gi] = sync_q.prev[gi] & ~sync_q.sync[gi];
		end
	endgenerate

endmodule // tmr_edge_sync

// [core/tmr_div.sv]
`timescale 1ns/10ps
module tmr_div
	import tmr_pkg::*;
#(
	parameter int RATIO = 2
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tick_in,
	output logic tick_out
);

	localparam int CW = (RATIO > 2) ? $clog2(RATIO) : 1;
	localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
	} tmr_div_type;

	tmr_div_type div_q;
	tmr_div_type div_d;

	// ****************************************
	// One output pulse per RATIO input pulses
	// ****************************************
	always_comb begin
		div_d = div_q;
		if (tick_in) begin
			if (div_q.cnt == LAST) begin
				div_d.cnt = '0;
			end else begin
				div_d.cnt = div_q.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	assign tick_out = tick_in & (div_q.cnt == LAST);

endmodule // tmr_div

// [core/tmr_top.sv]
`timescale 1ns/10ps
module tmr_top
	import tmr_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic count_pin,
	input wire logic trigger_pin,
	input wire logic slow_clk,
	input wire logic [1:0] serial_mode,
	output logic [7:0] rd_data,
	output logic irq,
	output logic rx_baud_tick,
	output logic tx_baud_tick,
	output logic overflow_wave_output,
	output logic overflow_wave_oe
);

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction

	// ****************************************
	// Pin synchronisers and rate dividers
	// ****************************************
	logic [SYNC_PINS-1:0] pins;
	logic [SYNC_PINS-1:0] falls;
	logic timer_tick;
	logic slow_tick;

	assign pins[PIN_COUNT] = count_pin;
	assign pins[PIN_TRIGGER] = trigger_pin;
	assign pins[PIN_SLOW] = slow_clk;

	tmr_edge_sync #(
		.WIDTH(SYNC_PINS)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_in(pins),
		.fall_pulse(falls)
	);

	// Free-running, so the first count after run takes one or two clocks
	// half system rate
	tmr_div #(
		.RATIO(TIMER_DIV)
	) u_div_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick_in(1'b1),
		.tick_out(timer_tick)
	);

	tmr_div #(
		.RATIO(SLOW_DIV)
	) u_div_slow (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick_in(falls[PIN_SLOW]),
		.tick_out(slow_tick)
	);

	// ****************************************
	// State
	// ****************************************
	tmr_state_type st_q;
	tmr_state_type st_d;

	// Every register and output clears on reset
	localparam tmr_state_type ST_RESET = '{
		control: RST_CONTROL,
		aux: RST_AUX,
		count: RST_COUNT,
		reload: RST_RELOAD,
		irq_status: '0,
		irq_mask: '0,
		rd_data: 8'h00,
		irq: 1'b0,
		rx_tick: 1'b0,
		tx_tick: 1'b0,
		wave: 1'b0,
		wave_oe: 1'b0
	};

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		logic baud_mode;
		logic reload_mode;
		logic count_edge;
		logic inc;
		logic ovf;
		logic trig;
		logic ovf_flag_set;
		logic serial_ok;
		logic [IRQ_BITS-1:0] events;
		logic [IRQ_BITS-1:0] w1c;

		baud_mode = 1'b0;
		reload_mode = 1'b0;
		count_edge = 1'b0;
		inc = 1'b0;
		ovf = 1'b0;
		trig = 1'b0;
		ovf_flag_set = 1'b0;
		serial_ok = 1'b0;
		events = '0;
		w1c = '0;

		st_d = st_q;
		st_d.rd_data = 8'h00;
		st_d.rx_tick = 1'b0;
		st_d.tx_tick = 1'b0;

		baud_mode = st_q.control[BIT_RX_BAUD] | st_q.control[BIT_TX_BAUD];
		reload_mode = baud_mode | ~st_q.control[BIT_CAP_SEL];

		// Pin edges arrive two clocks after the pin falls
		// count source select
		count_edge = st_q.aux[BIT_AUX_SLOW_SEL] ? slow_tick
			: falls[PIN_COUNT];

		if (st_q.control[BIT_RUN]) begin
			if (st_q.control[BIT_CT_SEL]) begin
				inc = count_edge;
			end else begin
				inc = timer_tick;
			end
		end

		// Overflow needs an increment, a write of ffff is not one
		// wrap from all ones
		ovf = inc & (st_q.count == COUNT_ALL_ONES);
		trig = st_q.control[BIT_TRIG_EN] & falls[PIN_TRIGGER];

		// ****************************************
		// Count and reload/capture pair
		// ****************************************
		if (inc) begin
			if (ovf) begin
				st_d.count = reload_mode ? st_q.reload : 16'h0000;
			end else begin
				st_d.count = st_q.count + 16'h0001;
			end
		end

		// Byte writes after the increment, so software wins a clash
		// No latching of the pair, reads while running may tear
		// software byte writes
		if (wr_en && hit(addr, ADDR_COUNT_LOW)) begin
			st_d.count[7:0] = wr_data;
		end
		if (wr_en && hit(addr, ADDR_COUNT_HIGH)) begin
			st_d.count[15:8] = wr_data;
		end
		if (wr_en && hit(addr, ADDR_RELOAD_LOW)) begin
			st_d.reload[7:0] = wr_data;
		end
		if (wr_en && hit(addr, ADDR_RELOAD_HIGH)) begin
			st_d.reload[15:8] = wr_data;
		end

		// After the byte writes, so a same-cycle trigger wins
		// Baud mode keeps the pair as reload value, flag only
		// trigger capture or reload
		if (trig && !baud_mode) begin
			if (st_q.control[BIT_CAP_SEL]) begin
				st_d.reload = st_q.count;
			end else begin
				st_d.count = st_q.reload;
			end
		end

		// ****************************************
		// Control and auxiliary registers
		// ****************************************
		if (wr_en && hit(addr, ADDR_CONTROL)) begin
			st_d.control = wr_data;
		end
		if (wr_en && hit(addr, ADDR_AUX)) begin
			st_d.aux = wr_data;
		end

		// After the register write, so a hardware set beats a clear
		// overflow flag, set wins
		ovf_flag_set = ovf & ~baud_mode;
		if (ovf_flag_set) begin
			st_d.control[BIT_OVF_FLAG] = 1'b1;
		end
		if (trig) begin
			st_d.control[BIT_EXT_FLAG] = 1'b1;
		end

		// ****************************************
		// Serial baud clocks
		// ****************************************
		serial_ok = (serial_mode == SERIAL_MODE_1)
			| (serial_mode == SERIAL_MODE_3);
		// Only the two timer-clocked serial modes take the ticks
		// overflow as baud clock
		st_d.rx_tick = ovf & serial_ok & st_q.control[BIT_RX_BAUD];
		st_d.tx_tick = ovf & serial_ok & st_q.control[BIT_TX_BAUD];

		// ****************************************
		// Overflow wave pin
		// ****************************************
		// toggle per overflow
		if (ovf) begin
			st_d.wave = ~st_q.wave;
		end
		// Enable follows the aux write two cycles later
		st_d.wave_oe = st_q.aux[BIT_AUX_WAVE_EN];

		// ****************************************
		// Interrupt status, mask and output
		// ****************************************
		events[BIT_IRQ_OVF] = ovf_flag_set;
		events[BIT_IRQ_EXT] = trig;
		if (wr_en && hit(addr, ADDR_IRQ_STATUS)) begin
			w1c = wr_data[IRQ_BITS-1:0];
		end
		st_d.irq_status = (st_q.irq_status & ~w1c) | events;
		if (wr_en && hit(addr, ADDR_IRQ_MASK)) begin
			st_d.irq_mask = wr_data[IRQ_BITS-1:0];
		end
		// Next-state values, so irq rises with its status bit
		st_d.irq = |(st_d.irq_status & st_d.irq_mask);

		// ****************************************
		// Read port, data one cycle after strobe
		// ****************************************
		if (rd_en) begin
			case (addr)
				ADDR_CONTROL: begin
					st_d.rd_data = st_q.control;
				end
				ADDR_AUX: begin
					st_d.rd_data = {6'h00,
						st_q.aux[BIT_AUX_WAVE_EN:0]};
				end
				ADDR_RELOAD_LOW: begin
					st_d.rd_data = st_q.reload[7:0];
				end
				ADDR_RELOAD_HIGH: begin
					st_d.rd_data = st_q.reload[15:8];
				end
				ADDR_COUNT_LOW: begin
					st_d.rd_data = st_q.count[7:0];
				end
				ADDR_COUNT_HIGH: begin
					st_d.rd_data = st_q.count[15:8];
				end
				ADDR_IRQ_STATUS: begin
					st_d.rd_data = {6'h00, st_q.irq_status};
				end
				ADDR_IRQ_MASK: begin
					st_d.rd_data = {6'h00, st_q.irq_mask};
				end
				// Unmapped addresses read as zero
				default: begin
					st_d.rd_data = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= ST_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Every output is a register bit
	assign rd_data = st_q.rd_data;
	assign irq = st_q.irq;
	assign rx_baud_tick = st_q.rx_tick;
	assign tx_baud_tick = st_q.tx_tick;
	assign overflow_wave_output = st_q.wave;
	assign overflow_wave_oe = st_q.wave_oe;

endmodule // tmr_top

// [testbench/tmr_pins.sv]
`timescale 1ns/10ps
module tmr_pins (
	input wire logic clk,
	input wire logic [1:0] go,
	input wire logic slow_on,
	output logic count_pin,
	output logic trigger_pin,
	output logic slow_clk
);
	initial begin
		count_pin = 1'b1;
		trigger_pin = 1'b1;
		slow_clk = 1'b1;
	end
	always @(posedge clk) begin
		count_pin <= !go[0];
		trigger_pin <= !go[1];
		if (slow_on) begin
			slow_clk <= !slow_clk;
		end
	end
endmodule // tmr_pins

// [testbench/tmr_sva.sv]
`timescale 1ns/10ps
module tmr_sva
	import tmr_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [1:0] serial_mode,
	input wire logic [7:0] rd_data,
	input wire logic rx_baud_tick,
	input wire logic tx_baud_tick,
	input wire logic overflow_wave_output,
	input wire logic overflow_wave_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	wire logic aux_wr = wr_en && addr == ADDR_AUX;
	property p_rd_idle;
		!$past(rd_en) |-> rd_data == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray data");
	property p_rx_mode;
		rx_baud_tick |-> $past(serial_mode[0]);
	endproperty
	a_rx_mode: assert property (p_rx_mode) else $error("rx mode");
	property p_tx_mode;
		tx_baud_tick |-> $past(serial_mode[0]);
	endproperty
	a_tx_mode: assert property (p_tx_mode) else $error("tx mode");
	property p_rx_pulse;
		rx_baud_tick |=> !rx_baud_tick;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse) else $error("rx pulse");
	property p_rx_wave;
		rx_baud_tick |-> $changed(overflow_wave_output);
	endproperty
	a_rx_wave: assert property (p_rx_wave) else $error("rx wave");
	property p_tx_wave;
		tx_baud_tick |-> $changed(overflow_wave_output);
	endproperty
	a_tx_wave: assert property (p_tx_wave) else $error("tx wave");
	property p_wave_gap;
		$changed(overflow_wave_output) |=> $stable(overflow_wave_output);
	endproperty
	a_wave_gap: assert property (p_wave_gap) else $error("wave gap");
	property p_oe_wr;
		$changed(overflow_wave_oe) |-> $past(aux_wr, 2);
	endproperty
	a_oe_wr: assert property (p_oe_wr) else $error("enable change");
endmodule // tmr_sva
bind tmr_top tmr_sva u_sva (.clk, .sys_rst, .addr, .wr_en, .rd_en,
	.serial_mode, .rd_data, .rx_baud_tick, .tx_baud_tick,
	.overflow_wave_output, .overflow_wave_oe);

// [testbench/timer2_reload_capture_bench.sv]
`timescale 1ns/10ps
module timer2_reload_capture_bench
	import tmr_pkg::*;
;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [1:0] go = 2'b00;
	logic slow_on = 1'b0;
	logic [1:0] serial_mode = 2'h0;
	logic count_pin, trigger_pin, slow_clk, irq, rx_t, tx_t, wave, oe;
	logic [7:0] rd_data;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	int nrx = 0;
	int ntx = 0;
	int nwv = 0;
	logic wave_seen = 1'b0;
	integer seed;
	tmr_top uut (.clk(clk), .sys_rst(sys_rst), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.count_pin(count_pin), .trigger_pin(trigger_pin),
		.slow_clk(slow_clk), .serial_mode(serial_mode),
		.rd_data(rd_data), .irq(irq), .rx_baud_tick(rx_t),
		.tx_baud_tick(tx_t), .overflow_wave_output(wave),
		.overflow_wave_oe(oe));
	tmr_pins u_pins (.clk(clk), .go(go), .slow_on(slow_on),
		.count_pin(count_pin), .trigger_pin(trigger_pin),
		.slow_clk(slow_clk));
	initial begin
		forever #10 clk = !clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		nrx <= nrx + int'(rx_t);
		ntx <= ntx + int'(tx_t);
		nwv <= nwv + int'(wave !== wave_seen);
		wave_seen <= wave;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	function automatic int ovf_cycles(input int reload);
		return (32'h10000 - reload) * TIMER_DIV;
	endfunction
	function automatic int slow_incs(input int toggles);
		return toggles / 2 / SLOW_DIV;
	endfunction
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask
	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h01, v[15:8]);
	endtask
	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 8'h01, v[15:8]);
	endtask
	task automatic pulse(input logic [1:0] m);
		go <= m;
		repeat (3) @(posedge clk);
		go <= 2'b00;
		repeat (6) @(posedge clk);
	endtask
	initial begin
		logic [7:0] d;
		logic [15:0] v, w, r;
		int n;
		int m;
		int e;
		seed = 32'h9d9540ef;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		for (int a = 'hc8; a <= 'hd0; a++) begin
			rd(8'(a), d);
			chk(16'(d), 16'h0000);
		end
		r = {1'b0, 15'($random(seed))};
		wr16(ADDR_RELOAD_LOW, r);
		rd16(ADDR_RELOAD_LOW, v);
		chk(v, r);
		wr(ADDR_CONTROL, 8'h04);
		repeat (100) @(posedge clk);
		wr(ADDR_CONTROL, 8'h00);
		rd16(ADDR_COUNT_LOW, v);
		chk(16'(v >= 16'd48 && v <= 16'd54), 16'h0001);
		repeat (10) @(posedge clk);
		rd16(ADDR_COUNT_LOW, w);
		chk(w, v);
		wr16(ADDR_COUNT_LOW, 16'hfffe);
		wr(ADDR_IRQ_MASK, 8'h01);
		wr(ADDR_CONTROL, 8'h04);
		for (n = 0; n < 50 && irq !== 1'b1; n++) @(posedge clk);
		wr(ADDR_CONTROL, 8'h80);
		rd(ADDR_CONTROL, d);
		chk(16'(d), 16'h0080);
		rd16(ADDR_COUNT_LOW, v);
		chk(16'(v - r <= 16'd4), 16'h0001);
		chk(16'(wave), 16'h0001);
		wr(ADDR_IRQ_STATUS, 8'h01);
		wr(ADDR_IRQ_MASK, 8'h00);
		wr16(ADDR_COUNT_LOW, 16'hfffe);
		wr(ADDR_CONTROL, 8'h04);
		repeat (20) @(posedge clk);
		chk(16'(irq), 16'h0000);
		chk(16'(wave), 16'h0000);
		wr(ADDR_IRQ_MASK, 8'h01);
		repeat (3) @(posedge clk);
		chk(16'(irq), 16'h0001);
		wr(ADDR_IRQ_STATUS, 8'h01);
		wr(ADDR_CONTROL, 8'h00);
		repeat (3) @(posedge clk);
		chk(16'(irq), 16'h0000);
		v = {1'b0, 15'($random(seed))};
		wr16(ADDR_COUNT_LOW, v);
		wr(ADDR_CONTROL, 8'h09);
		pulse(2'b10);
		rd16(ADDR_RELOAD_LOW, w);
		chk(w, v);
		rd(ADDR_CONTROL, d);
		chk(16'(d), 16'h0049);
		rd(ADDR_IRQ_STATUS, d);
		chk(16'(d), 16'h0002);
		wr(ADDR_CONTROL, 8'h08);
		wr16(ADDR_RELOAD_LOW, r);
		pulse(2'b10);
		rd16(ADDR_COUNT_LOW, w);
		chk(w, r);
		wr16(ADDR_COUNT_LOW, 16'h0000);
		wr(ADDR_CONTROL, 8'h06);
		repeat (5) pulse(2'b01);
		wr(ADDR_CONTROL, 8'h00);
		rd16(ADDR_COUNT_LOW, w);
		chk(w, 16'h0005);
		wr16(ADDR_COUNT_LOW, 16'h0000);
		wr(ADDR_AUX, 8'h01);
		wr(ADDR_CONTROL, 8'h06);
		slow_on <= 1'b1;
		repeat (64) @(posedge clk);
		slow_on <= 1'b0;
		repeat (8) @(posedge clk);
		rd16(ADDR_COUNT_LOW, w);
		chk(w, 16'(slow_incs(64)));
		wr16(ADDR_RELOAD_LOW, 16'hffe0);
		wr16(ADDR_COUNT_LOW, 16'hffe0);
		wr(ADDR_AUX, 8'h02);
		serial_mode <= SERIAL_MODE_1;
		wr(ADDR_CONTROL, 8'h35);
		n = nrx;
		m = nwv;
		e = 320 / ovf_cycles('hffe0);
		repeat (320) @(posedge clk);
		chk(16'(nrx - n >= e - 1 && nrx - n <= e + 1), 16'h0001);
		chk(16'(ntx - n), 16'(nrx - n));
		chk(16'(nwv - m), 16'(nrx - n));
		rd(ADDR_CONTROL, d);
		chk(16'(d), 16'h0035);
		chk(16'(oe), 16'h0001);
		serial_mode <= 2'h2;
		repeat (2) @(posedge clk);
		n = nrx;
		repeat (200) @(posedge clk);
		chk(16'(nrx - n), 16'h0000);
		serial_mode <= SERIAL_MODE_3;
		repeat (2) @(posedge clk);
		n = nrx;
		e = 200 / ovf_cycles('hffe0);
		repeat (200) @(posedge clk);
		chk(16'(nrx - n >= e - 1 && nrx - n <= e + 1), 16'h0001);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(ADDR_CONTROL, d);
		chk(16'(d), 16'h0000);
		rd16(ADDR_RELOAD_LOW, w);
		chk(w, 16'h0000);
		chk(16'(oe), 16'h0000);
		wr(ADDR_CONTROL, 8'h00);
		report_and_stop();
	end
endmodule // timer2_reload_capture_bench
